// ==== src/fsic_pkg.sv ====
// Constants for the five-source interrupt control block.
// Assumes the core addresses control words 0 to 3 with a 2-bit word and a 2-bit bit position.
package fsic_pkg;

	// Control word addresses.
	localparam logic [1:0] WORD_EXTERNAL   = 2'h0;
	localparam logic [1:0] WORD_TIMERS     = 2'h2;
	localparam logic [1:0] WORD_ADC_SERIAL = 2'h3;

	// Bit positions inside the external word.
	localparam logic [1:0] POS_GLOBAL_ENABLE = 2'h0;

	// Sources in priority order, index 0 highest: external, timer B, timer C, A/D, serial.
	localparam int NUM_SRC = 5;
	localparam logic [9:0] FLAG_WORD = {WORD_ADC_SERIAL, WORD_ADC_SERIAL, WORD_TIMERS, WORD_TIMERS, WORD_EXTERNAL};
	localparam logic [9:0] FLAG_POS  = {2'h2, 2'h0, 2'h2, 2'h0, 2'h2};
	localparam logic [9:0] MASK_POS  = {2'h3, 2'h1, 2'h3, 2'h1, 2'h3};

	// Reset values of the control bits.
	localparam logic       ENABLE_RESET = 1'b0;
	localparam logic [4:0] FLAG_RESET   = 5'h00;
	localparam logic [4:0] MASK_RESET   = 5'h1F;

	// Vector addresses, one per source; plain defaults.
	localparam int         PC_W    = 14;
	localparam logic [13:0] VEC_EXT    = 14'h0002;
	localparam logic [13:0] VEC_TIMERB = 14'h0004;
	localparam logic [13:0] VEC_TIMERC = 14'h0006;
	localparam logic [13:0] VEC_ADC    = 14'h0008;
	localparam logic [13:0] VEC_SERIAL = 14'h000A;

	// Interrupt processing sequence, Gray coded along the path.
	typedef enum logic [1:0] {
		SEQ_IDLE   = 2'b00,
		SEQ_FINISH = 2'b01,
		SEQ_PUSH   = 2'b11,
		SEQ_JUMP   = 2'b10
	} fsic_seq_t;

endpackage : fsic_pkg

// ==== src/fsic_ext_edge.sv ====
// Synchroniser and falling-edge detector for the external interrupt pin.
// Assumes the pin may change at any time relative to CLK.
`timescale 1ns/100ps
module fsic_ext_edge (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Pin side
	input  wire logic pin_n,
	input  wire logic enable,
	// Event side
	output logic      fall_pulse
);

	logic meta_r,  meta_nxt;
	logic sync_r,  sync_nxt;
	logic prev_r,  prev_nxt;
	logic pulse_r, pulse_nxt;

	////////////////////////////////////////////////////////////////////////////////
	// The first stage feeds only the second; edges are judged on settled copies.
	// sync then edge
	always_comb begin
		meta_nxt  = pin_n;
		sync_nxt  = meta_r;
		prev_nxt  = sync_r;
		pulse_nxt = enable && prev_r && !sync_r;
	end

	// Idle level is high, so a pin held low over reset raises one event once reset ends, if selected.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_r  <= 1'b1;
			sync_r  <= 1'b1;
			prev_r  <= 1'b1;
			pulse_r <= 1'b0;
		end else begin
			meta_r  <= meta_nxt;
			sync_r  <= sync_nxt;
			prev_r  <= prev_nxt;
			pulse_r <= pulse_nxt;
		end
	end

	assign fall_pulse = pulse_r;

	////////////////////////////////////////////////////////////////////////////////
	property p_single_pulse;
		@(posedge clk) disable iff (!rst_n)
		pulse_r |=> !pulse_r;
	endproperty
	a_single_pulse: assert property (p_single_pulse) else $error("edge pulse lasted two cycles");

endmodule : fsic_ext_edge

// ==== src/fsic_ctrl.sv ====
// Interrupt control for five sources: flags, masks, global enable, priority and entry sequence.
// Also the restart bookkeeping that tells a stop release by the restart input from a reset.
// Assumes the core drives bit set, clear and test strobes and signals each instruction end.
`timescale 1ns/100ps

// Overview of operation
// - Exactly five sources: external pin, timer B, timer C, serial, A/D.
// - Software cannot set request flags; only source events set them, software clears.
// - Reset clears global enable and flags, and sets every mask.
// - Request needs flag one and mask zero; processing also needs global enable.
// - Priority: external, timer B, timer C, A/D, serial lowest.
// - First cycle finishes the instruction; global enable clears after two cycles.
// - Cycles two and three push carry, status and program counter.
// - Third cycle loads program counter with the chosen vector.
// - Processing clears global enable; return-from-interrupt sets it; one enables.
// - When selected, a falling edge on the external pin sets its flag.
// - Timer B overflow sets timer B flag, word 2 bit 0.
// - Timer C overflow sets timer C flag, word 2 bit 2.
// - Serial completion or suspension sets serial flag, word 3 bit 2.
// - A/D completion sets A/D flag, word 3 bit 0.
// - Mask zero passes, one blocks; flag one means pending.
// - Control bits live in words 0, 2 and 3, bit set, clear and test access.
// - Accumulator, carry and datapath registers are undefined after any release or reset.
// - Port mode B bit 3 kept over restart release, cleared by reset.
// - RAM-valid flag reads one after restart release, zero after reset.
// - Pending unmasked request with global enable zero makes standby or stop a no-op.
// - A/D mask, word 3 bit 1, blocks when one, passes when zero.
module fsic_ctrl
	import fsic_pkg::*;
(
	// Clock and reset
	input  wire logic        CLK,
	input  wire logic        RST_N,
	// Bit set, clear and test access to control words
	input  wire logic [1:0]  BIT_ADDR,
	input  wire logic [1:0]  BIT_POS,
	input  wire logic        BIT_SET,
	input  wire logic        BIT_CLR,
	input  wire logic        BIT_TEST,
	output logic             TEST_BIT,
	// Interrupt sources
	input  wire logic        EXTERNAL_IRQ_INPUT_N,
	input  wire logic        EXT_IRQ_SELECT,
	input  wire logic        TIMER_B_OVERFLOW,
	input  wire logic        TIMER_C_OVERFLOW,
	input  wire logic        ADC_DONE,
	input  wire logic        SERIAL_DONE,
	input  wire logic        SERIAL_SUSPEND,
	// Core sequencer
	input  wire logic        INSN_END,
	input  wire logic        RETURN_FROM_INTERRUPT_INSTR,
	output logic             IRQ_BUSY,
	output logic             PUSH_FLAGS,
	output logic             PUSH_PC,
	output logic             PC_LOAD,
	output logic [13:0]      VECTOR,
	output logic             GLOBAL_IRQ_ENABLE,
	output logic             LOW_POWER_NOP,
	// Stop release bookkeeping
	input  wire logic        STOP_MODE,
	input  wire logic        STOP_RELEASE_INPUT,
	input  wire logic        PORT_MODE_B_WE,
	input  wire logic        PORT_MODE_B_BIT3_WDATA,
	output logic             PORT_MODE_B_BIT3,
	output logic             RAM_VALID_FLAG
);

	////////////////////////////////////////////////////////////////////////////////
	// Declarations.
	logic                ie_r,      ie_nxt;
	logic [NUM_SRC-1:0]  flag_r,    flag_nxt;
	logic [NUM_SRC-1:0]  mask_r,    mask_nxt;
	fsic_seq_t           seq_r,     seq_nxt;
	logic [13:0]         vec_r,     vec_nxt;
	logic                test_r,    test_nxt;
	logic                nop_r,     nop_nxt;
	logic                pmb3_r,    pmb3_nxt;
	logic                rvalid_r,  rvalid_nxt;
	logic                push_f_r,  push_f_nxt;
	logic                push_p_r,  push_p_nxt;
	logic                load_r,    load_nxt;
	logic                busy_r,    busy_nxt;
	logic                ext_event, restart, accept;
	logic [NUM_SRC-1:0]  hw_set, sw_clr, mask_set, mask_clr, req;
	logic [3:0]          word_img;

	////////////////////////////////////////////////////////////////////////////////
	// External pin edge detection.
	// select gates pin
	fsic_ext_edge u_ext_edge (
		.clk        (CLK),
		.rst_n      (RST_N),
		.pin_n      (EXTERNAL_IRQ_INPUT_N),
		.enable     (EXT_IRQ_SELECT),
		.fall_pulse (ext_event)
	);

	assign hw_set = {SERIAL_DONE || SERIAL_SUSPEND, ADC_DONE, TIMER_C_OVERFLOW, TIMER_B_OVERFLOW, ext_event};

	// A restart only counts while stopped; elsewhere the input is ignored.
	assign restart = STOP_MODE && STOP_RELEASE_INPUT;

	////////////////////////////////////////////////////////////////////////////////
	// Per-source decode of bit operations and the masked request.
	for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
		assign sw_clr[i]   = BIT_CLR && (BIT_ADDR == FLAG_WORD[2*i +: 2]) && (BIT_POS == FLAG_POS[2*i +: 2]);
		assign mask_set[i] = BIT_SET && (BIT_ADDR == FLAG_WORD[2*i +: 2]) && (BIT_POS == MASK_POS[2*i +: 2]);
		assign mask_clr[i] = BIT_CLR && (BIT_ADDR == FLAG_WORD[2*i +: 2]) && (BIT_POS == MASK_POS[2*i +: 2]);
		assign req[i] = flag_r[i] && !mask_r[i];
	end

	assign accept = (seq_r == SEQ_IDLE) && ie_r && (|req) && INSN_END;

	////////////////////////////////////////////////////////////////////////////////
	// Control bits: flags, masks and global enable.
	always_comb begin
		flag_nxt = flag_r;
		mask_nxt = mask_r;
		ie_nxt   = ie_r;
		for (int i = 0; i < NUM_SRC; i++) begin
			flag_nxt[i] = hw_set[i] || (flag_r[i] && !sw_clr[i]);
			mask_nxt[i] = mask_set[i] || (mask_r[i] && !mask_clr[i]);
		end
		if (BIT_ADDR == WORD_EXTERNAL && BIT_POS == POS_GLOBAL_ENABLE && BIT_SET) begin
			ie_nxt = 1'b1;
		end else if (BIT_ADDR == WORD_EXTERNAL && BIT_POS == POS_GLOBAL_ENABLE && BIT_CLR) begin
			ie_nxt = 1'b0;
		end
		if (RETURN_FROM_INTERRUPT_INSTR) begin
			ie_nxt = 1'b1;
		end
		if (seq_r == SEQ_PUSH) begin
			ie_nxt = 1'b0;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N || restart) begin
			ie_r   <= ENABLE_RESET;
			flag_r <= FLAG_RESET;
			mask_r <= MASK_RESET;
		end else begin
			ie_r   <= ie_nxt;
			flag_r <= flag_nxt;
			mask_r <= mask_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Entry sequence: finish, push flags, push counter and jump.
	always_comb begin
		seq_nxt    = seq_r;
		vec_nxt    = vec_r;
		push_f_nxt = 1'b0;
		push_p_nxt = 1'b0;
		load_nxt   = 1'b0;
		unique case (seq_r)
			SEQ_IDLE: begin
				if (accept) begin
					seq_nxt = SEQ_FINISH;
					if (req[0]) begin
						vec_nxt = VEC_EXT;
					end else if (req[1]) begin
						vec_nxt = VEC_TIMERB;
					end else if (req[2]) begin
						vec_nxt = VEC_TIMERC;
					end else if (req[3]) begin
						vec_nxt = VEC_ADC;
					end else begin
						vec_nxt = VEC_SERIAL;
					end
				end
			end
			SEQ_FINISH: begin
				seq_nxt    = SEQ_PUSH;
				push_f_nxt = 1'b1;
			end
			SEQ_PUSH: begin
				seq_nxt    = SEQ_JUMP;
				push_p_nxt = 1'b1;
				load_nxt   = 1'b1;
			end
			SEQ_JUMP: begin
				seq_nxt = SEQ_IDLE;
			end
		endcase
		busy_nxt = (seq_nxt != SEQ_IDLE);
	end

	// A restart aborts any sequence since the core restarts from address zero.
	always_ff @(posedge CLK) begin
		if (!RST_N || restart) begin
			seq_r    <= SEQ_IDLE;
			vec_r    <= 14'h0000;
			push_f_r <= 1'b0;
			push_p_r <= 1'b0;
			load_r   <= 1'b0;
			busy_r   <= 1'b0;
		end else begin
			seq_r    <= seq_nxt;
			busy_r   <= busy_nxt;
			vec_r    <= vec_nxt;
			push_f_r <= push_f_nxt;
			push_p_r <= push_p_nxt;
			load_r   <= load_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bit test read-back and low-power cancel.
	always_comb begin
		unique case (BIT_ADDR)
			WORD_EXTERNAL:   word_img = {mask_r[0], flag_r[0], 1'b0, ie_r};
			WORD_TIMERS:     word_img = {mask_r[2], flag_r[2], mask_r[1], flag_r[1]};
			WORD_ADC_SERIAL: word_img = {mask_r[4], flag_r[4], mask_r[3], flag_r[3]};
			default:         word_img = 4'h0;
		endcase
		test_nxt = BIT_TEST ? word_img[BIT_POS] : test_r;
		nop_nxt = !ie_r && (|req);
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			test_r <= 1'b0;
			nop_r  <= 1'b0;
		end else begin
			test_r <= test_nxt;
			nop_r  <= nop_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Restart bookkeeping. The datapath registers are not held here and get no initial value.
	// datapath left undefined
	always_comb begin
		pmb3_nxt = PORT_MODE_B_WE ? PORT_MODE_B_BIT3_WDATA : pmb3_r;
		rvalid_nxt = restart ? 1'b1 : rvalid_r;
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			pmb3_r   <= 1'b0;
			rvalid_r <= 1'b0;
		end else begin
			pmb3_r   <= pmb3_nxt;
			rvalid_r <= rvalid_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs, all straight from flip-flops.
	assign TEST_BIT          = test_r;
	assign IRQ_BUSY          = busy_r;
	assign PUSH_FLAGS        = push_f_r;
	assign PUSH_PC           = push_p_r;
	assign PC_LOAD           = load_r;
	assign VECTOR            = vec_r;
	assign GLOBAL_IRQ_ENABLE = ie_r;
	assign LOW_POWER_NOP     = nop_r;
	assign PORT_MODE_B_BIT3  = pmb3_r;
	assign RAM_VALID_FLAG    = rvalid_r;

	////////////////////////////////////////////////////////////////////////////////
	// Checks.
	property p_reset_vals;
		@(posedge CLK) !RST_N |=> (!ie_r && flag_r == 5'h00 && mask_r == 5'h1F && !RAM_VALID_FLAG);
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");
	property p_no_sw_set;
		@(posedge CLK) disable iff (!RST_N)
		(BIT_SET && !flag_r[1] && !hw_set[1] && !restart) |=> !flag_r[1];
	endproperty
	a_no_sw_set: assert property (p_no_sw_set) else $error("software set a request flag");
	property p_set_wins;
		@(posedge CLK) disable iff (!RST_N)
		(TIMER_B_OVERFLOW && !restart) |=> flag_r[1];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("timer B event lost");
	property p_sequence;
		@(posedge CLK) disable iff (!RST_N || restart)
		accept |=> (!PUSH_FLAGS && IRQ_BUSY) ##1 (PUSH_FLAGS && !PC_LOAD) ##1 (PUSH_PC && PC_LOAD);
	endproperty
	a_sequence: assert property (p_sequence) else $error("entry sequence out of order");
	property p_ie_clear;
		@(posedge CLK) disable iff (!RST_N || restart)
		accept |-> ##3 (!GLOBAL_IRQ_ENABLE && PC_LOAD);
	endproperty
	a_ie_clear: assert property (p_ie_clear) else $error("enable not cleared by third cycle");
	property p_prio;
		@(posedge CLK) disable iff (!RST_N || restart)
		(accept && req[0]) |-> ##3 (PC_LOAD && VECTOR == VEC_EXT);
	endproperty
	a_prio: assert property (p_prio) else $error("external source lost priority");
	property p_rti;
		@(posedge CLK) disable iff (!RST_N || restart)
		(RETURN_FROM_INTERRUPT_INSTR && seq_r != SEQ_PUSH) |=> GLOBAL_IRQ_ENABLE;
	endproperty
	a_rti: assert property (p_rti) else $error("return did not set enable");
	property p_nop;
		@(posedge CLK) disable iff (!RST_N)
		(!ie_r && |req) |=> LOW_POWER_NOP;
	endproperty
	a_nop: assert property (p_nop) else $error("sleep not cancelled");
	property p_ram_valid;
		@(posedge CLK) disable iff (!RST_N)
		restart |=> RAM_VALID_FLAG;
	endproperty
	a_ram_valid: assert property (p_ram_valid) else $error("RAM valid not set by restart");
	property p_pmb3_keep;
		@(posedge CLK) disable iff (!RST_N)
		(restart && !PORT_MODE_B_WE) |=> $stable(PORT_MODE_B_BIT3);
	endproperty
	a_pmb3_keep: assert property (p_pmb3_keep) else $error("port mode bit lost over restart");

endmodule : fsic_ctrl

// ==== testbench/fsic_core_model.sv ====
// Behavioural core sequencer that sits on the far side of the interrupt control block.
// Assumes the block drives the entry pulses from registers on the rising edge of clk.
`timescale 1ns/100ps
module fsic_core_model
	import fsic_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Pace select, high ends an instruction every third cycle
	input  wire logic        slow,
	// Entry sequence from the block
	input  wire logic        irq_busy,
	input  wire logic        push_flags,
	input  wire logic        push_pc,
	input  wire logic        pc_load,
	input  wire logic [13:0] vector,
	output logic             insn_end,
	// What the core saw during the last entry
	output logic [13:0]      pc_r,
	output logic [3:0]       flags_at_r,
	output logic [3:0]       pc_at_r
);
	logic [1:0] pace_r;
	logic [3:0] step_r;

	////////////////////////////////////////////////////////////////////////////////
	// no boundary during entry
	// The core executes nothing while the block owns the sequence, so no boundary is shown.
	assign insn_end = !irq_busy && (!slow || pace_r == 2'h0);

	// push and jump
	// Step counts busy cycles so the bench can see in which cycle each push came.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pace_r     <= 2'h0;
			step_r     <= 4'h0;
			pc_r       <= 14'h0000;
			flags_at_r <= 4'hF;
			pc_at_r    <= 4'hF;
		end else begin
			pace_r <= (pace_r == 2'h2) ? 2'h0 : pace_r + 2'h1;
			step_r <= irq_busy ? step_r + 4'h1 : 4'h0;
			if (push_flags)
				flags_at_r <= step_r;
			if (push_pc)
				pc_at_r <= step_r;
			if (pc_load)
				pc_r <= vector;
		end
	end
endmodule : fsic_core_model

// ==== testbench/five_source_interrupt_control_tb.sv ====
// Self-checking bench for the five-source interrupt control block.
// Assumes a core model on the sequencer side; the bench plays software and the peripherals.
`timescale 1ns/100ps
module five_source_interrupt_control_tb;
	import fsic_pkg::*;

	logic        clk = 1'b0, rst_n = 1'b0, slow = 1'b0;
	logic [1:0]  bit_addr = 2'h0, bit_pos = 2'h0;
	logic        bit_set = 1'b0, bit_clr = 1'b0, bit_test = 1'b0, test_bit;
	logic        pin_n = 1'b1, ext_sel = 1'b0, tb_ovf = 1'b0, tc_ovf = 1'b0, adc_done = 1'b0;
	logic        ser_done = 1'b0, ser_susp = 1'b0, insn_end, ret = 1'b0;
	logic        busy, push_flags, push_pc, pc_load, gie, lp_nop;
	logic        stop_mode = 1'b0, stop_rel = 1'b0, pmb_we = 1'b0, pmb_wd = 1'b0, pmb3, ram_valid;
	logic [13:0] vector, core_pc;
	logic [3:0]  flags_at, pc_at;
	logic [13:0] vecs [5] = '{VEC_EXT, VEC_TIMERB, VEC_TIMERC, VEC_ADC, VEC_SERIAL};
	int          fail_count = 0;
	int          cmp_count  = 0;

	always #5 clk = ~clk;

	fsic_ctrl dut (.CLK(clk), .RST_N(rst_n), .BIT_ADDR(bit_addr), .BIT_POS(bit_pos), .BIT_SET(bit_set),
		.BIT_CLR(bit_clr), .BIT_TEST(bit_test), .TEST_BIT(test_bit), .EXTERNAL_IRQ_INPUT_N(pin_n),
		.EXT_IRQ_SELECT(ext_sel), .TIMER_B_OVERFLOW(tb_ovf), .TIMER_C_OVERFLOW(tc_ovf), .ADC_DONE(adc_done),
		.SERIAL_DONE(ser_done), .SERIAL_SUSPEND(ser_susp), .INSN_END(insn_end),
		.RETURN_FROM_INTERRUPT_INSTR(ret), .IRQ_BUSY(busy), .PUSH_FLAGS(push_flags), .PUSH_PC(push_pc),
		.PC_LOAD(pc_load), .VECTOR(vector), .GLOBAL_IRQ_ENABLE(gie), .LOW_POWER_NOP(lp_nop),
		.STOP_MODE(stop_mode), .STOP_RELEASE_INPUT(stop_rel), .PORT_MODE_B_WE(pmb_we),
		.PORT_MODE_B_BIT3_WDATA(pmb_wd), .PORT_MODE_B_BIT3(pmb3), .RAM_VALID_FLAG(ram_valid));

	fsic_core_model core (.clk(clk), .rst_n(rst_n), .slow(slow), .irq_busy(busy), .push_flags(push_flags),
		.push_pc(push_pc), .pc_load(pc_load), .vector(vector), .insn_end(insn_end), .pc_r(core_pc),
		.flags_at_r(flags_at), .pc_at_r(pc_at));

	////////////////////////////////////////////////////////////////////////////////
	// Comparison and closing.
	task automatic chk(input string n, input logic [13:0] e, input logic [13:0] g);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_sim

	////////////////////////////////////////////////////////////////////////////////
	// One bit operation, one cycle wide; the result is settled when the task returns.
	task automatic op(input logic [1:0] a, input logic [1:0] p, input logic s, input logic c, input logic t);
		@(posedge clk);
		bit_addr <= a;
		bit_pos  <= p;
		bit_set  <= s;
		bit_clr  <= c;
		bit_test <= t;
		@(posedge clk);
		bit_set  <= 1'b0;
		bit_clr  <= 1'b0;
		bit_test <= 1'b0;
		#1;
	endtask : op

	task automatic rd(input logic [1:0] a, input logic [1:0] p, input logic e, input string n);
		op(a, p, 1'b0, 1'b0, 1'b1);
		chk(n, {13'h0, e}, {13'h0, test_bit});
	endtask : rd

	// Source event: 0 pin fall, 1 timer B, 2 timer C, 3 A/D, 4 serial done, 5 serial suspend.
	task automatic src(input int i);
		@(posedge clk);
		tb_ovf   <= (i == 1);
		tc_ovf   <= (i == 2);
		adc_done <= (i == 3);
		ser_done <= (i == 4);
		ser_susp <= (i == 5);
		if (i == 0)
			pin_n <= 1'b0;
		@(posedge clk);
		{tb_ovf, tc_ovf, adc_done, ser_done, ser_susp} <= 5'h00;
		pin_n <= 1'b1;
		repeat (6) @(posedge clk);
		#1;
	endtask : src

	// Waits for the jump of one entry and checks the whole sequence as the core saw it.
	task automatic entry(input logic [13:0] v);
		int n;
		for (n = 0; n < 30 && pc_load !== 1'b1; n++) begin
			@(posedge clk);
			#1;
		end
		chk("vector", v, vector);
		chk("enable cleared", 14'h0, {13'h0, gie});
		@(posedge clk);
		#1;
		chk("core pc", v, core_pc);
		chk("flags push cycle", 14'h1, {10'h0, flags_at});
		chk("pc push cycle", 14'h2, {10'h0, pc_at});
	endtask : entry

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		int k;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		// Reset values of every control bit, plus one reserved word.
		for (k = 0; k < NUM_SRC; k++) begin
			rd(FLAG_WORD[2*k+:2], FLAG_POS[2*k+:2], 1'b0, "flag reset");
			rd(FLAG_WORD[2*k+:2], MASK_POS[2*k+:2], 1'b1, "mask reset");
		end
		rd(WORD_EXTERNAL, POS_GLOBAL_ENABLE, 1'b0, "enable reset");
		op(2'h1, 2'h0, 1'b1, 1'b0, 1'b0);
		rd(2'h1, 2'h0, 1'b0, "reserved word");
		$display("test reset values done");
		// Software cannot set a flag.
		for (k = 0; k < NUM_SRC; k++) begin
			op(FLAG_WORD[2*k+:2], FLAG_POS[2*k+:2], 1'b1, 1'b0, 1'b0);
			rd(FLAG_WORD[2*k+:2], FLAG_POS[2*k+:2], 1'b0, "flag set refused");
		end
		$display("test software set done");
		// Pin fall ignored while not selected, then counted once when selected.
		src(0);
		rd(WORD_EXTERNAL, FLAG_POS[1:0], 1'b0, "pin not selected");
		@(posedge clk);
		ext_sel <= 1'b1;
		src(0);
		rd(WORD_EXTERNAL, FLAG_POS[1:0], 1'b1, "pin fall");
		op(WORD_EXTERNAL, FLAG_POS[1:0], 1'b0, 1'b1, 1'b0);
		rd(WORD_EXTERNAL, FLAG_POS[1:0], 1'b0, "pin one edge");
		for (k = 1; k <= 5; k++) begin
			src(k);
			rd(FLAG_WORD[2*(k-k/5)+:2], FLAG_POS[2*(k-k/5)+:2], 1'b1, "source flag");
			op(FLAG_WORD[2*(k-k/5)+:2], FLAG_POS[2*(k-k/5)+:2], 1'b0, 1'b1, 1'b0);
		end
		// Hardware set and software clear in one cycle.
		@(posedge clk);
		bit_addr <= WORD_TIMERS;
		bit_pos  <= FLAG_POS[3:2];
		bit_clr  <= 1'b1;
		tb_ovf   <= 1'b1;
		@(posedge clk);
		bit_clr <= 1'b0;
		tb_ovf  <= 1'b0;
		rd(WORD_TIMERS, FLAG_POS[3:2], 1'b1, "set beats clear");
		$display("test source events done");
		// All five pending and unmasked, enable off: low power is a no-op.
		src(0);
		for (k = 2; k <= 4; k++)
			src(k);
		for (k = 0; k < NUM_SRC; k++)
			op(FLAG_WORD[2*k+:2], MASK_POS[2*k+:2], 1'b0, 1'b1, 1'b0);
		chk("low power nop", 14'h1, {13'h0, lp_nop});
		chk("no entry while disabled", 14'h0, {13'h0, busy});
		// Entries in priority order, each handler clears its own flag.
		for (k = 0; k < NUM_SRC; k++) begin
			if (k == 0)
				op(WORD_EXTERNAL, POS_GLOBAL_ENABLE, 1'b1, 1'b0, 1'b0);
			else begin
				@(posedge clk);
				ret  <= 1'b1;
				slow <= (k >= 3);
				@(posedge clk);
				ret <= 1'b0;
			end
			entry(vecs[k]);
			op(FLAG_WORD[2*k+:2], FLAG_POS[2*k+:2], 1'b0, 1'b1, 1'b0);
		end
		// The no-op level is registered, so it drops one cycle after the last flag clears.
		@(posedge clk);
		#1;
		chk("no pending", 14'h0, {13'h0, lp_nop});
		// A masked request never starts an entry.
		src(3);
		op(WORD_ADC_SERIAL, MASK_POS[7:6], 1'b1, 1'b0, 1'b0);
		op(WORD_EXTERNAL, POS_GLOBAL_ENABLE, 1'b1, 1'b0, 1'b0);
		repeat (10) @(posedge clk);
		#1;
		chk("masked kept enable", 14'h1, {13'h0, gie});
		$display("test priority and entry done");
		// Restart release keeps port bit and marks RAM valid; reset clears both.
		@(posedge clk);
		pmb_we <= 1'b1;
		pmb_wd <= 1'b1;
		@(posedge clk);
		pmb_we    <= 1'b0;
		stop_mode <= 1'b1;
		stop_rel  <= 1'b1;
		@(posedge clk);
		stop_mode <= 1'b0;
		stop_rel  <= 1'b0;
		@(posedge clk);
		#1;
		chk("port bit kept", 14'h1, {13'h0, pmb3});
		chk("ram valid", 14'h1, {13'h0, ram_valid});
		chk("restart enable", 14'h0, {13'h0, gie});
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		#1;
		chk("port bit reset", 14'h0, {13'h0, pmb3});
		chk("ram not valid", 14'h0, {13'h0, ram_valid});
		$display("test restart and reset done");
		end_sim();
	end

	// Watchdog well beyond the few hundred cycles the tests need.
	initial begin
		#200000;
		fail_count++;
		end_sim();
	end
endmodule : five_source_interrupt_control_tb
